//--- logic/mem_decode_pkg.sv
/*
 * constants shared by the program and data memory decoder and its gpr store.
 * assumes a single 100 mhz core clock and synchronous active-high reset.
 */
package mem_decode_pkg;

  // ***************************************
  // program side
  // ***************************************
  localparam int PC_W = 13;                      // program counter width
  localparam int INSTR_W = 14;                   // instruction word width
  localparam int PROG_AW_LARGE = 13;             // 8k words
  localparam int PROG_AW_SMALL = 12;             // 4k words
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [12:0] PC_STEP = 13'h0001;

  // ***************************************
  // data side
  // ***************************************
  localparam int DATA_W = 8;
  localparam int OFS_W = 7;                      // in-bank address, 00h..7fh
  localparam int PHYS_W = 9;                     // bank select bits over in-bank address
  localparam int GPR_DEPTH = 512;
  localparam int BANK_SEL_HIGH_BIT = 6;
  localparam int BANK_SEL_LOW_BIT = 5;
  localparam int IND_BANK_BIT = 7;               // status bit that extends the pointer
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] POINTER_RESET = 8'h00;

  // in-bank offsets of the registers this block keeps or treats specially
  localparam logic [6:0] OFS_INDIRECT = 7'h00;   // not a physical register
  localparam logic [6:0] OFS_PROG_LOW = 7'h02;
  localparam logic [6:0] OFS_STATUS = 7'h03;
  localparam logic [6:0] OFS_POINTER = 7'h04;
  localparam logic [6:0] OFS_PROG_LATCH = 7'h0a;
  localparam logic [6:0] OFS_IRQ_CTRL = 7'h0b;
  localparam logic [6:0] OFS_COMMON = 7'h70;     // 70h..7fh shared by all banks

  // first gpr offset per bank: banks 0/1 hold 32 sfr slots, banks 2/3 hold 16
  localparam logic [6:0] SFR_TOP_LOW_BANKS = 7'h20;
  localparam logic [6:0] SFR_TOP_HIGH_BANKS = 7'h10;

endpackage : mem_decode_pkg

//--- logic/gpr_port_if.sv
/*
 * carrier between the decoder and the general purpose register store.
 * assumes both ends share sys_clk; the store answers reads in the same cycle.
 */
interface gpr_port_if;
  import mem_decode_pkg::*;

  logic we;                          // write strobe
  logic [PHYS_W-1:0] addr;           // folded physical address
  logic [DATA_W-1:0] wdata;          // write data
  logic [DATA_W-1:0] rdata;          // read data, combinational

  modport decoder (output we, output addr, output wdata, input rdata);
  modport store (input we, input addr, input wdata, output rdata);
endinterface : gpr_port_if

//--- logic/gpr_store.sv
/*
 * static ram for the general purpose registers of all four banks.
 * assumes the decoder only writes gpr locations; sfr slots of the array stay unused.
 */
module gpr_store (
  input wire logic sys_clk,          // core clock
  gpr_port_if.store port             // access from the decoder
);
  import mem_decode_pkg::*;

  logic [DATA_W-1:0] mem [GPR_DEPTH];

  // ***************************************
  // storage
  // ***************************************
  // no reset: gpr contents are undefined after power up, as on the core
  always_ff @(posedge sys_clk) begin
    if (port.we) begin
      mem[port.addr] <= port.wdata;
    end
  end

  // asynchronous read keeps the data answer at one cycle
  assign port.rdata = mem[port.addr];

endmodule : gpr_store

//--- logic/memory_map_bank_decode.sv
/*
 * program counter and data memory bank decode of a small microcontroller core.
 * assumes the core's fetch and data paths on sys_clk, and peripherals that answer sfr reads combinationally.
 */
module memory_map_bank_decode
  import mem_decode_pkg::*;
#(
  parameter bit PROG_LARGE = 1'b1                       // 1: 8k words, 0: 4k words
) (
  input wire logic sys_clk,                             // 100 mhz core clock
  input wire logic srst,                                // synchronous reset, active high
  input wire logic fetch_advance,                       // step to next instruction
  input wire logic fetch_jump,                          // load jump_target
  input wire logic [mem_decode_pkg::PC_W-1:0] jump_target, // branch or call target
  input wire logic irq_take,                            // interrupt accepted this cycle
  output logic [mem_decode_pkg::PC_W-1:0] pc_value,     // full program counter
  output logic [mem_decode_pkg::PC_W-1:0] instr_addr,   // wrapped fetch address
  input wire logic data_req,                            // data access this cycle
  input wire logic data_we,                             // 1 write, 0 read
  input wire logic [mem_decode_pkg::OFS_W-1:0] data_addr, // direct in-bank address
  input wire logic [mem_decode_pkg::DATA_W-1:0] data_wdata, // write data
  output logic data_rvalid,                             // read data valid pulse
  output logic [mem_decode_pkg::DATA_W-1:0] data_rdata, // read data
  output logic [mem_decode_pkg::DATA_W-1:0] status_value, // status register
  output logic [mem_decode_pkg::DATA_W-1:0] pointer_value, // indirect pointer
  output logic sfr_strobe,                              // peripheral sfr access pulse
  output logic sfr_we,                                  // peripheral sfr write
  output logic [mem_decode_pkg::PHYS_W-1:0] sfr_addr,   // folded sfr address
  output logic [mem_decode_pkg::DATA_W-1:0] sfr_wdata,  // peripheral write data
  input wire logic [mem_decode_pkg::DATA_W-1:0] sfr_rdata // peripheral read data
);
  import mem_decode_pkg::*;

  // mask keeps only the address bits that the implemented store decodes
  localparam int PROG_AW = PROG_LARGE ? PROG_AW_LARGE : PROG_AW_SMALL;
  localparam logic [PC_W-1:0] PROG_MASK = PC_W'((1 << PROG_AW) - 1);

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] iaddr;
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] pointer;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic sfr_strobe;
    logic sfr_we;
    logic [PHYS_W-1:0] sfr_addr;
    logic [DATA_W-1:0] sfr_wdata;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // gpr storage sits on the data side only; fetch never touches it
  gpr_port_if gpr ();

  gpr_store u_gpr (
    .sys_clk(sys_clk),
    .port(gpr.store)
  );

  // ***************************************
  // decode helpers
  // ***************************************
  // registers every bank reaches at the bank 0 location
  function automatic logic is_mirrored(input logic [OFS_W-1:0] ofs);
    is_mirrored = (ofs == OFS_INDIRECT) || (ofs == OFS_PROG_LOW) || (ofs == OFS_STATUS) ||
      (ofs == OFS_POINTER) || (ofs == OFS_PROG_LATCH) || (ofs == OFS_IRQ_CTRL);
  endfunction : is_mirrored

  // sfr boundary per bank; no bank is gpr only
  function automatic logic [OFS_W-1:0] sfr_top(input logic [1:0] bank);
    sfr_top = bank[1] ? SFR_TOP_HIGH_BANKS : SFR_TOP_LOW_BANKS;
  endfunction : sfr_top

  // next pc and decode results of the data request in the current cycle
  logic [PC_W-1:0] pc_target;
  logic indirect;
  logic [PHYS_W-1:0] phys;
  logic [1:0] bank;
  logic [OFS_W-1:0] ofs;
  logic hit_sfr;
  logic hit_null;
  logic [PHYS_W-1:0] fold_addr;
  logic [DATA_W-1:0] rd_mux;

  // ***************************************
  // program counter
  // ***************************************
  // interrupt wins over a jump in the same cycle, jump over a step
  always_comb begin
    pc_target = state_reg.pc;
    if (irq_take) begin
      pc_target = IRQ_VECTOR;
    end else if (fetch_jump) begin
      pc_target = jump_target;
    end else if (fetch_advance) begin
      pc_target = state_reg.pc + PC_STEP;
    end
  end

  // ***************************************
  // data address formation
  // ***************************************
  // in-bank address 00h means go through the pointer; the pointer's ninth bit comes from status
  always_comb begin
    indirect = (data_addr == OFS_INDIRECT);
    if (indirect) begin
      phys = {state_reg.status[IND_BANK_BIT], state_reg.pointer};
    end else begin
      phys = {state_reg.status[BANK_SEL_HIGH_BIT], state_reg.status[BANK_SEL_LOW_BIT], data_addr};
    end
    bank = phys[PHYS_W-1:OFS_W];
    ofs = phys[OFS_W-1:0];
    hit_sfr = (ofs < sfr_top(bank));
    hit_null = indirect && (ofs == OFS_INDIRECT);
    // mirrored sfrs and the common gpr window fold to bank 0
    if ((hit_sfr && is_mirrored(ofs)) || (ofs >= OFS_COMMON)) begin
      fold_addr = {2'b00, ofs};
    end else begin
      fold_addr = phys;
    end
  end

  // gpr store sees every address but only gpr writes land
  assign gpr.addr = fold_addr;
  assign gpr.we = data_req && data_we && !hit_sfr;
  assign gpr.wdata = data_wdata;

  // read source: local registers, peripherals or static ram
  always_comb begin
    rd_mux = 8'h00;
    if (hit_null) begin
      rd_mux = 8'h00;
    end else if (hit_sfr && ofs == OFS_STATUS) begin
      rd_mux = state_reg.status;
    end else if (hit_sfr && ofs == OFS_POINTER) begin
      rd_mux = state_reg.pointer;
    end else if (hit_sfr) begin
      rd_mux = sfr_rdata;
    end else begin
      rd_mux = gpr.rdata;
    end
  end

  // ***************************************
  // next state
  // ***************************************
  always_comb begin
    state_next = state_reg;
    state_next.pc = pc_target;
    // only the low bits the implemented size needs reach the store
    state_next.iaddr = pc_target & PROG_MASK;
    state_next.rvalid = data_req && !data_we;
    state_next.rdata = (data_req && !data_we) ? rd_mux : state_reg.rdata;
    state_next.sfr_strobe = 1'b0;
    state_next.sfr_we = 1'b0;
    // status and pointer live here, so peripherals never see an access to them
    // the null location is refused: no strobe and no write
    if (data_req && hit_sfr && !hit_null) begin
      if (data_we && ofs == OFS_STATUS) begin
        state_next.status = data_wdata;
      end else if (data_we && ofs == OFS_POINTER) begin
        state_next.pointer = data_wdata;
      end else if (ofs != OFS_STATUS && ofs != OFS_POINTER) begin
        state_next.sfr_strobe = 1'b1;
        state_next.sfr_we = data_we;
        state_next.sfr_addr = fold_addr;
        state_next.sfr_wdata = data_wdata;
      end
    end
  end

  // ***************************************
  // state register
  // ***************************************
  // reset points fetch at the reset vector; data registers take fixed values
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg.pc <= RESET_VECTOR;
      state_reg.iaddr <= RESET_VECTOR;
      state_reg.status <= STATUS_RESET;
      state_reg.pointer <= POINTER_RESET;
      state_reg.rvalid <= 1'b0;
      state_reg.rdata <= 8'h00;
      state_reg.sfr_strobe <= 1'b0;
      state_reg.sfr_we <= 1'b0;
      state_reg.sfr_addr <= 9'h000;
      state_reg.sfr_wdata <= 8'h00;
    end else begin
      state_reg <= state_next;
    end
  end

  // every output is a field of the state register
  assign pc_value = state_reg.pc;
  assign instr_addr = state_reg.iaddr;
  assign status_value = state_reg.status;
  assign pointer_value = state_reg.pointer;
  assign data_rvalid = state_reg.rvalid;
  assign data_rdata = state_reg.rdata;
  assign sfr_strobe = state_reg.sfr_strobe;
  assign sfr_we = state_reg.sfr_we;
  assign sfr_addr = state_reg.sfr_addr;
  assign sfr_wdata = state_reg.sfr_wdata;

endmodule : memory_map_bank_decode

//--- tb/mem_decode_assertions.sv
/*
 * port checker for the program counter and data bank decode.
 * assumes a bind onto the top module and the single sys_clk domain.
 */
module mem_decode_assertions #(
  parameter bit PROG_LARGE = 1'b1 // program size
) (
  input wire logic sys_clk, // clock
  input wire logic srst, // reset
  input wire logic fetch_advance, // step
  input wire logic fetch_jump, // jump
  input wire logic [12:0] jump_target, // target
  input wire logic irq_take, // irq
  input wire logic [12:0] pc_value, // pc
  input wire logic [12:0] instr_addr, // fetch addr
  input wire logic data_req, // access
  input wire logic data_we, // write
  input wire logic [6:0] data_addr, // offset
  input wire logic [7:0] data_wdata, // wdata
  input wire logic data_rvalid, // read valid
  input wire logic [7:0] status_value, // status
  input wire logic sfr_strobe, // sfr pulse
  input wire logic [8:0] sfr_addr // sfr addr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] bank_prev;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // bank bits of the request cycle, kept apart so the address check is not self-referring
  always_ff @(posedge sys_clk) begin
    bank_prev <= status_value[6:5];
  end
  sequence s_rd;
    data_req && !data_we;
  endsequence
  sequence s_wr(a);
    data_req && data_we && data_addr == a;
  endsequence
  a_reset_clear: assert property (disable iff (1'b0) srst |=> pc_value == 13'h0000 && status_value == 8'h00)
    else $error("reset left pc or status set");
  a_irq_vector: assert property (irq_take |=> pc_value == 13'h0004)
    else $error("pc missed the irq vector");
  a_pc_step: assert property (fetch_advance && !fetch_jump && !irq_take |=> pc_value == $past(pc_value) + 13'h0001)
    else $error("pc did not step");
  a_fetch_wrap: assert property (instr_addr == (PROG_LARGE ? pc_value : (pc_value & 13'h0fff)))
    else $error("fetch address not wrapped");
  a_read_pulse: assert property (s_rd |=> data_rvalid)
    else $error("read gave no valid pulse");
  a_status_write: assert property (s_wr(7'h03) |=> status_value == $past(data_wdata))
    else $error("status write lost");
  a_sfr_bank: assert property (s_wr(7'h05) |=> sfr_strobe && sfr_addr == {bank_prev, 7'h05})
    else $error("sfr address not banked");
  a_mirror_fold: assert property (data_req && data_addr == 7'h0b |=> sfr_strobe && sfr_addr == 9'h00b)
    else $error("mirrored sfr not folded");
  a_gpr_quiet: assert property (data_req && data_addr >= 7'h70 |=> !sfr_strobe)
    else $error("gpr access strobed an sfr");
  a_write_quiet: assert property (data_req && data_we |=> !data_rvalid)
    else $error("write raised read valid");
  a_sfr_boundary: assert property (data_req && data_addr == 7'h18 |=> sfr_strobe == !bank_prev[1])
    else $error("sfr boundary decoded wrong");
endmodule : mem_decode_assertions

//--- tb/sfr_periph_model.sv
/*
 * peripheral sfr model on the far side of the sfr port.
 * assumes reads are answered combinationally from the request-cycle address.
 */
module sfr_periph_model (
  input wire logic sys_clk, // clock
  input wire logic sfr_strobe, // access pulse
  input wire logic sfr_we, // write
  input wire logic [8:0] sfr_addr, // folded address
  input wire logic [7:0] sfr_wdata, // write data
  input wire logic [8:0] rd_addr, // request address
  output logic [7:0] sfr_rdata // read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] regs [512];
  // writes land on the strobe
  always_ff @(posedge sys_clk) begin
    if (sfr_strobe && sfr_we) begin
      regs[sfr_addr] <= sfr_wdata;
    end
  end
  // unwritten slots read unknown, no kinder than real peripherals
  assign sfr_rdata = regs[rd_addr];
endmodule : sfr_periph_model

//--- tb/tb_top.sv
/*
 * self-checking bench for the pc and bank decode, 4k program variant.
 * assumes the package and design files are compiled first.
 */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, srst = 1'b1, fetch_advance = 1'b0, fetch_jump = 1'b0, irq_take = 1'b0;
  logic data_req = 1'b0, data_we = 1'b0, data_rvalid, sfr_strobe, sfr_we;
  logic [12:0] jump_target = 13'h0000, pc_value, instr_addr, pc_start;
  logic [6:0] data_addr = 7'h00;
  logic [7:0] data_wdata = 8'h00, data_rdata, status_value, pointer_value, sfr_wdata, sfr_rdata;
  logic [8:0] sfr_addr;
  int errors = 0, samples_checked = 0;
  always #5 sys_clk = ~sys_clk;
  // small variant so the wrap at 1000h is reachable
  memory_map_bank_decode #(.PROG_LARGE(1'b0)) dut (.sys_clk, .srst, .fetch_advance, .fetch_jump, .jump_target,
    .irq_take, .pc_value, .instr_addr, .data_req, .data_we, .data_addr, .data_wdata, .data_rvalid, .data_rdata,
    .status_value, .pointer_value, .sfr_strobe, .sfr_we, .sfr_addr, .sfr_wdata, .sfr_rdata);
  sfr_periph_model peri (.sys_clk, .sfr_strobe, .sfr_we, .sfr_addr, .sfr_wdata,
    .rd_addr({status_value[6:5], data_addr}), .sfr_rdata);
  // ****************
  // helpers
  // ****************
  task automatic chk(input string name, input logic [12:0] seen, input logic [12:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    if (errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  // one fetch request, held over exactly one edge
  task automatic fetch(input logic adv, input logic jmp, input logic irq, input logic [12:0] tgt);
    @(negedge sys_clk);
    {fetch_advance, fetch_jump, irq_take, jump_target} = {adv, jmp, irq, tgt};
    @(negedge sys_clk);
    {fetch_advance, fetch_jump, irq_take} = 3'b000;
  endtask : fetch
  // one data access; results are settled when it returns
  task automatic acc(input logic we, input logic [6:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    {data_req, data_we, data_addr, data_wdata} = {1'b1, we, a, d};
    @(negedge sys_clk);
    data_req = 1'b0;
  endtask : acc
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk("rvalid", 13'(data_rvalid), 13'h0001);
    chk("rdata", 13'(data_rdata), 13'(exp));
  endtask : rd
  // ****************
  // scenarios
  // ****************
  task automatic t_fetch;
    chk("pc reset", pc_value, 13'h0000);
    fetch(1'b1, 1'b0, 1'b0, 13'h0000);
    chk("pc step", pc_value, 13'h0001);
    fetch(1'b1, 1'b1, 1'b0, 13'h0fff);
    fetch(1'b1, 1'b0, 1'b0, 13'h0000);
    chk("pc wrap", pc_value, 13'h1000);
    chk("fetch wrap", instr_addr, 13'h0000);
    fetch(1'b1, 1'b1, 1'b1, 13'h0123);
    chk("irq vector", pc_value, 13'h0004);
  endtask : t_fetch
  task automatic t_banks;
    for (int b = 0; b < 4; b++) begin
      acc(1'b1, 7'h03, {1'b0, 2'(b), 5'h00});
      chk("status", 13'(status_value), 13'(b * 32));
      acc(1'b1, 7'h40, 8'(8'ha0 + b));
      acc(1'b1, 7'h18, 8'(8'hc0 + b));
      acc(1'b1, 7'h05, 8'(8'h50 + b));
      chk("sfr addr", 13'(sfr_addr), 13'(b * 128 + 5));
      chk("sfr we", 13'(sfr_we), 13'h0001);
      chk("sfr wdata", 13'(sfr_wdata), 13'(8'h50 + b));
    end
    for (int b = 0; b < 4; b++) begin
      acc(1'b1, 7'h03, {1'b0, 2'(b), 5'h00});
      rd(7'h40, 8'(8'ha0 + b));
      rd(7'h05, 8'(8'h50 + b));
      rd(7'h18, 8'(8'hc0 + b));
    end
  endtask : t_banks
  task automatic t_mirror;
    acc(1'b1, 7'h03, 8'h60);
    acc(1'b1, 7'h7f, 8'h9e);
    acc(1'b1, 7'h0b, 8'h77);
    chk("mirror addr", 13'(sfr_addr), 13'h000b);
    rd(7'h03, 8'h60);
    rd(7'h7f, 8'h9e);
    // back in bank 0 the common byte and the mirrored sfr must be the very same ones
    acc(1'b1, 7'h03, 8'h00);
    rd(7'h7f, 8'h9e);
    rd(7'h0b, 8'h77);
  endtask : t_mirror
  // reset in mid-run, with pc, status and pointer away from their reset values
  task automatic t_reset;
    acc(1'b1, 7'h04, 8'h5a);
    fetch(1'b1, 1'b0, 1'b0, 13'h0000);
    srst = 1'b1;
    @(negedge sys_clk);
    srst = 1'b0;
    chk("pc after reset", pc_value, 13'h0000);
    chk("fetch after reset", instr_addr, 13'h0000);
    chk("status after reset", 13'(status_value), 13'h0000);
    chk("pointer after reset", 13'(pointer_value), 13'h0000);
  endtask : t_reset
  // indirect access with a fetch running in the same cycles
  task automatic t_indirect;
    acc(1'b1, 7'h03, 8'h00);
    acc(1'b1, 7'h04, 8'h45);
    chk("pointer", 13'(pointer_value), 13'h0045);
    pc_start = pc_value;
    fetch_advance = 1'b1;
    acc(1'b1, 7'h00, 8'h3c);
    fetch_advance = 1'b0;
    chk("pc beside data", pc_value, pc_start + 13'h0002);
    rd(7'h45, 8'h3c);
    acc(1'b1, 7'h04, 8'h00);
    rd(7'h00, 8'h00);
  endtask : t_indirect
  initial begin
    #100000;
    errors++;
    end_sim();
  end
  initial begin
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    t_fetch();
    t_banks();
    t_reset();
    t_mirror();
    t_indirect();
    end_sim();
  end
endmodule : tb_top

bind memory_map_bank_decode mem_decode_assertions #(.PROG_LARGE(PROG_LARGE)) chk_u (.sys_clk, .srst,
  .fetch_advance, .fetch_jump, .jump_target, .irq_take, .pc_value, .instr_addr, .data_req, .data_we,
  .data_addr, .data_wdata, .data_rvalid, .status_value, .sfr_strobe, .sfr_addr);
